/* common/pcrb_pkg.sv */
// constants and carrier types shared by the control register logic
package pcrb_pkg;
  // ==========================================================
  // register select codes
  localparam logic [1:0] PCRB_RS_PORT_A = 2'h0;
  localparam logic [1:0] PCRB_RS_CTRL_A = 2'h1;
  localparam logic [1:0] PCRB_RS_PORT_B = 2'h2;
  localparam logic [1:0] PCRB_RS_CTRL_B = 2'h3;
  // ==========================================================
  // control register field positions
  localparam int PCRB_CR_IRQ_EN = 0;
  localparam int PCRB_CR_EDGE_SEL = 1;
  localparam int PCRB_CR_DIR_ACCESS = 2;
  localparam int PCRB_CR_AUX_IRQ_EN = 3;
  localparam int PCRB_CR_AUX_LEVEL = 3;
  localparam int PCRB_CR_AUX_EDGE_SEL = 4;
  localparam int PCRB_CR_AUX_OUT = 5;
  localparam int PCRB_CR_FLAG_AUX = 6;
  localparam int PCRB_CR_FLAG_EDGE = 7;
  // ==========================================================
  // reset values and write mask
  localparam logic [7:0] PCRB_RESET_VAL = 8'h00;
  localparam logic [7:0] PCRB_CR_WR_MASK = 8'h3F;
  localparam int PCRB_LINES = 4;
  // ==========================================================
  // host bus request carrier
  typedef struct packed {
    logic cs;
    logic rw;
    logic reg_select_hi;
    logic reg_select_lo;
    logic [7:0] wdata;
  } pcrb_bus_req_s;
endpackage

/* src/pcrb_adapter.sv */
// control register logic of the two-section peripheral adapter
// How it works
// [R1] bit 2 steers data versus direction access
// [R2] active edge sets flag when line input
// [R3] host writes never touch flag bits
// [R4] peripheral data read clears section flags
// [R5] bit 5 low: aux line is interrupt input
// [R6] bit 5 high: aux line driven output
// [R7] bit 0 gates edge flag onto irq
// [R8] bit 1 picks rising or falling edge
// [R9] select code decodes four register locations
// [R10] reset zeroes all registers, inputs, irqs off
// [R11] direction bit one makes line output
// [R12] strobe between edges needed to arm
// [R13] irq low while enabled flag set
module pcrb_adapter
  import pcrb_pkg::*;
#(
  parameter int W = 8
)(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic bus_e,
  input wire pcrb_bus_req_s bus_req,
  output logic [7:0] bus_rdata,
  input wire logic a_edge_input,
  input wire logic b_edge_input,
  input wire logic a_aux_line_in,
  output logic a_aux_line_out,
  output logic a_aux_line_oe,
  input wire logic b_aux_line_in,
  output logic b_aux_line_out,
  output logic b_aux_line_oe,
  input wire logic [W-1:0] port_a_in,
  output logic [W-1:0] port_a_out,
  output logic [W-1:0] port_a_oe,
  input wire logic [W-1:0] port_b_in,
  output logic [W-1:0] port_b_out,
  output logic [W-1:0] port_b_oe,
  output logic a_irq_n,
  output logic b_irq_n
);
  // ==========================================================
  // state
  typedef struct packed {
    logic [7:0] section_a_control;
    logic [7:0] section_b_control;
    logic [W-1:0] out_a;
    logic [W-1:0] out_b;
    logic [W-1:0] dir_a;
    logic [W-1:0] dir_b;
    logic [W-1:0] pa_meta;
    logic [W-1:0] pa_sync;
    logic [W-1:0] pb_meta;
    logic [W-1:0] pb_sync;
    logic [7:0] rdata;
  } pcrb_state_s;

  pcrb_state_s state_ff;
  pcrb_state_s nxt_state;
  logic access;
  logic [1:0] code;
  logic clear_a;
  logic clear_b;
  logic [PCRB_LINES-1:0] flags;
  logic [PCRB_LINES-1:0] line_raw;
  logic [PCRB_LINES-1:0] line_rise;
  logic [PCRB_LINES-1:0] line_input;
  logic [PCRB_LINES-1:0] line_clear;
  logic [W-1:0] read_a;
  logic [W-1:0] read_b;

  // ==========================================================
  // bus decode
  assign access = bus_e && bus_req.cs;
  assign code = {bus_req.reg_select_hi, bus_req.reg_select_lo}; // see [R9]
  // data reads clear flags only when bit 2 routes to the data register
  assign clear_a = access && bus_req.rw && (code == PCRB_RS_PORT_A)
    && state_ff.section_a_control[PCRB_CR_DIR_ACCESS]; // see [R4]
  assign clear_b = access && bus_req.rw && (code == PCRB_RS_PORT_B)
    && state_ff.section_b_control[PCRB_CR_DIR_ACCESS]; // see [R4]
  // side A reads the pins, side B reads its latch for output bits
  assign read_a = state_ff.pa_sync[W-1:0];
  assign read_b = (state_ff.out_b & state_ff.dir_b) | (state_ff.pb_sync & ~state_ff.dir_b);

  // ==========================================================
  // per-line wiring: 0 a edge, 1 a aux, 2 b edge, 3 b aux
  assign line_raw = {b_aux_line_in, b_edge_input, a_aux_line_in, a_edge_input};
  assign line_rise = {state_ff.section_b_control[PCRB_CR_AUX_EDGE_SEL],
                      state_ff.section_b_control[PCRB_CR_EDGE_SEL],
                      state_ff.section_a_control[PCRB_CR_AUX_EDGE_SEL],
                      state_ff.section_a_control[PCRB_CR_EDGE_SEL]}; // see [R8]
  // edge inputs are always inputs; aux lines only while bit 5 is low
  assign line_input = {~state_ff.section_b_control[PCRB_CR_AUX_OUT], 1'b1,
                       ~state_ff.section_a_control[PCRB_CR_AUX_OUT], 1'b1}; // see [R5]
  assign line_clear = {clear_b, clear_b, clear_a, clear_a};

  genvar gi;
  generate
    for (gi = 0; gi < PCRB_LINES; gi++) begin : g_line
      pcrb_edge_flag u_flag (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .line_in(line_raw[gi]),
        .rise_sel(line_rise[gi]),
        .input_mode(line_input[gi]),
        .e_strobe(bus_e),
        .clear(line_clear[gi]),
        .flag(flags[gi])
      );
    end
  endgenerate

  // ==========================================================
  // register next state
  always_comb begin
    nxt_state = state_ff;
    nxt_state.pa_meta = port_a_in;
    nxt_state.pa_sync = state_ff.pa_meta;
    nxt_state.pb_meta = port_b_in;
    nxt_state.pb_sync = state_ff.pb_meta;
    if (access && !bus_req.rw) begin
      unique case (code)
        PCRB_RS_PORT_A: begin
          if (state_ff.section_a_control[PCRB_CR_DIR_ACCESS]) begin
            nxt_state.out_a = bus_req.wdata[W-1:0]; // see [R1]
          end else begin
            nxt_state.dir_a = bus_req.wdata[W-1:0]; // see [R1]
          end
        end
        PCRB_RS_CTRL_A: begin
          // flag bits are not stored here, so writes cannot reach them
          nxt_state.section_a_control = bus_req.wdata & PCRB_CR_WR_MASK; // see [R3]
        end
        PCRB_RS_PORT_B: begin
          if (state_ff.section_b_control[PCRB_CR_DIR_ACCESS]) begin
            nxt_state.out_b = bus_req.wdata[W-1:0]; // see [R1]
          end else begin
            nxt_state.dir_b = bus_req.wdata[W-1:0]; // see [R1]
          end
        end
        PCRB_RS_CTRL_B: begin
          nxt_state.section_b_control = bus_req.wdata & PCRB_CR_WR_MASK; // see [R3]
        end
      endcase
    end
    if (access && bus_req.rw) begin
      unique case (code)
        PCRB_RS_PORT_A: begin
          nxt_state.rdata = state_ff.section_a_control[PCRB_CR_DIR_ACCESS]
            ? read_a : state_ff.dir_a; // see [R1]
        end
        PCRB_RS_CTRL_A: begin
          nxt_state.rdata = {flags[0], flags[1], state_ff.section_a_control[5:0]};
        end
        PCRB_RS_PORT_B: begin
          nxt_state.rdata = state_ff.section_b_control[PCRB_CR_DIR_ACCESS]
            ? read_b : state_ff.dir_b; // see [R1]
        end
        PCRB_RS_CTRL_B: begin
          nxt_state.rdata = {flags[2], flags[3], state_ff.section_b_control[5:0]};
        end
      endcase
    end
  end

  // synchronous reset zeroes every register
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_ff <= '0; // see [R10]
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ==========================================================
  // outputs
  assign bus_rdata = state_ff.rdata;
  assign port_a_out = state_ff.out_a;
  assign port_a_oe = state_ff.dir_a; // see [R11]
  assign port_b_out = state_ff.out_b;
  assign port_b_oe = state_ff.dir_b; // see [R11]
  // aux output follows bit 3 as a plain level; handshake sub-modes left out
  assign a_aux_line_oe = state_ff.section_a_control[PCRB_CR_AUX_OUT]; // see [R6]
  assign a_aux_line_out = a_aux_line_oe && state_ff.section_a_control[PCRB_CR_AUX_LEVEL];
  assign b_aux_line_oe = state_ff.section_b_control[PCRB_CR_AUX_OUT]; // see [R6]
  assign b_aux_line_out = b_aux_line_oe && state_ff.section_b_control[PCRB_CR_AUX_LEVEL];
  // request low while any enabled flag is set
  assign a_irq_n = !((flags[0] && state_ff.section_a_control[PCRB_CR_IRQ_EN])
    || (flags[1] && state_ff.section_a_control[PCRB_CR_AUX_IRQ_EN]
        && !state_ff.section_a_control[PCRB_CR_AUX_OUT])); // see [R7] see [R13]
  assign b_irq_n = !((flags[2] && state_ff.section_b_control[PCRB_CR_IRQ_EN])
    || (flags[3] && state_ff.section_b_control[PCRB_CR_AUX_IRQ_EN]
        && !state_ff.section_b_control[PCRB_CR_AUX_OUT])); // see [R7] see [R13]

  // ==========================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // own disable: the default one would abort every attempt started in reset
  a_reset_zero: assert property (@(posedge sys_clk) disable iff (1'b0) // see [R10]
    !reset_n |=> state_ff.section_a_control == PCRB_RESET_VAL && port_a_oe == '0
      && state_ff.section_b_control == PCRB_RESET_VAL && port_b_oe == '0
      && !a_aux_line_oe && !b_aux_line_oe && a_irq_n && b_irq_n)
    else $error("reset left a register set");
  a_aux_no_flag: assert property ( // see [R5]
    state_ff.section_a_control[PCRB_CR_AUX_OUT] |=> !$rose(flags[1]))
    else $error("aux flag set while aux line is an output");
  a_dir_select: assert property ( // see [R1]
    (access && !bus_req.rw && code == PCRB_RS_PORT_A
      && !state_ff.section_a_control[PCRB_CR_DIR_ACCESS])
    |=> port_a_oe == $past(bus_req.wdata) && port_a_out == $past(port_a_out))
    else $error("direction access misrouted");
  a_ctrl_write: assert property ( // see [R3]
    (access && !bus_req.rw && code == PCRB_RS_CTRL_B)
    |=> state_ff.section_b_control == ($past(bus_req.wdata) & PCRB_CR_WR_MASK))
    else $error("control write stored flag bits");
  a_ctrl_read: assert property ( // see [R9]
    (access && bus_req.rw && code == PCRB_RS_CTRL_A)
    |=> bus_rdata == {$past(flags[0]), $past(flags[1]),
                      $past(state_ff.section_a_control[5:0])})
    else $error("control read returned wrong value");
  a_read_clear: assert property ( // see [R4]
    (clear_b && $past(clear_b) == 1'b0 && !b_edge_input && !b_aux_line_in
      && flags[2]) |=> ##[0:3] !flags[2])
    else $error("data read did not clear flag");
  a_irq_gate: assert property ( // see [R7]
    (flags[0] && !state_ff.section_a_control[PCRB_CR_IRQ_EN] && !flags[1]) |-> a_irq_n)
    else $error("masked flag raised request");
  a_aux_drive: assert property ( // see [R6]
    $rose(state_ff.section_b_control[PCRB_CR_AUX_OUT]) |-> b_aux_line_oe
      && b_aux_line_out == state_ff.section_b_control[PCRB_CR_AUX_LEVEL])
    else $error("aux line not driven in output mode");
endmodule

/* src/pcrb_edge_flag.sv */
// one control line: synchroniser, edge sense arming and sticky flag
module pcrb_edge_flag
  import pcrb_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic line_in,
  input wire logic rise_sel,
  input wire logic input_mode,
  input wire logic e_strobe,
  input wire logic clear,
  output logic flag
);
  // ==========================================================
  // state
  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
    logic armed;
    logic flag;
  } pcrb_edge_state_s;

  pcrb_edge_state_s state_ff;
  pcrb_edge_state_s nxt_state;
  logic edge_evt;
  logic set_evt;

  // next state: edge seen only on the synchronised copy
  always_comb begin
    nxt_state = state_ff;
    nxt_state.meta = line_in;
    nxt_state.sync = state_ff.meta;
    nxt_state.prev = state_ff.sync;
    edge_evt = (state_ff.sync == rise_sel) && (state_ff.prev != rise_sel); // see [R8]
    set_evt = input_mode && state_ff.armed && edge_evt; // see [R2]
    // an edge consumes the arming; a strobe at the idle level restores it
    if (edge_evt) begin
      nxt_state.armed = 1'b0;
    end
    if (e_strobe && (state_ff.sync != rise_sel)) begin
      nxt_state.armed = 1'b1; // see [R12]
    end
    // set wins over a clear in the same cycle so no event is lost
    if (clear) begin
      nxt_state.flag = 1'b0; // see [R4]
    end
    if (set_evt) begin
      nxt_state.flag = 1'b1; // see [R2]
    end
  end

  // register the state
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign flag = state_ff.flag;

  // ==========================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  a_flag_cause: assert property ( // see [R2]
    $rose(flag) |-> $past(input_mode) && $past(state_ff.armed) && $past(edge_evt))
    else $error("flag rose without an armed active edge");
  a_arm_need: assert property ( // see [R12]
    (edge_evt && !state_ff.armed && !clear) |=> flag == $past(flag))
    else $error("unarmed edge changed the flag");
  a_clear_drop: assert property ( // see [R4]
    (clear && !set_evt) |=> !flag ##1 (flag -> $past(set_evt)))
    else $error("clear did not drop the flag");
endmodule

/* test/pcrb_adapter_tb_top.sv */
// self-checking bench for the adapter control register logic
module pcrb_adapter_tb_top
  import pcrb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, reset_n, bus_e, a_irq_n, b_irq_n;
  pcrb_bus_req_s bus_req;
  logic [7:0] bus_rdata, rv, exp_v;
  logic [3:0] lines;
  logic [7:0] p_out [2];
  logic [7:0] p_oe [2];
  logic [1:0] aux_out, aux_oe;
  logic [1:0] cc, pc;
  int n_mismatch, tests_run;
  localparam logic [7:0] PINS = 8'h5A;
  // ==========================================================
  // clock and watchdog
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // the whole run needs well under 1500 cycles
  initial begin
    #(3000 * 50);
    n_mismatch++;
    give_verdict();
  end
  pcrb_host_model host (.sys_clk(sys_clk), .bus_e(bus_e), .bus_req(bus_req),
    .bus_rdata(bus_rdata));
  pcrb_adapter #(.W(8)) uut (.sys_clk(sys_clk), .reset_n(reset_n), .bus_e(bus_e),
    .bus_req(bus_req), .bus_rdata(bus_rdata), .a_edge_input(lines[0]),
    .b_edge_input(lines[2]), .a_aux_line_in(lines[1]), .a_aux_line_out(aux_out[0]),
    .a_aux_line_oe(aux_oe[0]), .b_aux_line_in(lines[3]), .b_aux_line_out(aux_out[1]),
    .b_aux_line_oe(aux_oe[1]), .port_a_in(PINS), .port_a_out(p_out[0]),
    .port_a_oe(p_oe[0]), .port_b_in(PINS), .port_b_out(p_out[1]), .port_b_oe(p_oe[1]),
    .a_irq_n(a_irq_n), .b_irq_n(b_irq_n));
  // ==========================================================
  // helpers
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // one control line: arm at the inactive level, make the active edge, then clear
  task automatic flag_case(input int s, input int ln, input logic rise, input logic en);
    logic [7:0] c;
    c = ln ? {3'b000, rise, en, 3'b100} : {5'b00001, rise, en};
    cc = s ? PCRB_RS_CTRL_B : PCRB_RS_CTRL_A;
    pc = s ? PCRB_RS_PORT_B : PCRB_RS_PORT_A;
    @(negedge sys_clk) lines[s * 2 + ln] = ~rise;
    cyc(4);
    host.wr(cc, c);
    host.rd(pc, rv); // bus strobe at the inactive level arms the sense
    @(negedge sys_clk) lines[s * 2 + ln] = rise;
    cyc(4);
    chk("irq", {7'h0, s ? b_irq_n : a_irq_n}, {7'h0, ~en});
    host.rd(cc, rv);
    chk("ctrl flags", rv, {ln == 0, ln == 1, c[5:0]});
    host.rd(pc, rv);
    host.rd(cc, rv);
    chk("flags cleared", rv, {2'b00, c[5:0]});
    chk("irq released", {7'h0, s ? b_irq_n : a_irq_n}, 8'h01);
    // a second edge pair with no strobe between must leave the flag clear
    @(negedge sys_clk) lines[s * 2 + ln] = ~rise;
    cyc(4);
    @(negedge sys_clk) lines[s * 2 + ln] = rise;
    cyc(4);
    chk("unarmed irq", {7'h0, s ? b_irq_n : a_irq_n}, 8'h01);
    host.rd(cc, rv);
    chk("unarmed flags", rv, {2'b00, c[5:0]});
  endtask
  // ==========================================================
  // main sequence
  initial begin
    reset_n = 1'b0;
    lines = 4'h0;
    n_mismatch = 0;
    tests_run = 0;
    cyc(5);
    reset_n = 1'b1;
    for (int s = 0; s < 2; s++) begin
      cc = s ? PCRB_RS_CTRL_B : PCRB_RS_CTRL_A;
      pc = s ? PCRB_RS_PORT_B : PCRB_RS_PORT_A;
      host.rd(cc, rv);
      chk("ctrl reset", rv, PCRB_RESET_VAL);
      chk("reset port dir", p_oe[s], 8'h00);
      chk("reset aux dir", {7'h0, aux_oe[s]}, 8'h00);
      chk("reset irq", {7'h0, a_irq_n & b_irq_n}, 8'h01);
      // direction register first, then the output latch
      exp_v = 8'hA5 ^ 8'(s);
      host.wr(cc, 8'h00);
      host.wr(pc, exp_v);
      chk("direction", p_oe[s], exp_v);
      host.rd(pc, rv);
      chk("direction read", rv, exp_v);
      host.wr(cc, 8'h04);
      host.wr(pc, 8'h3C);
      chk("latch", p_out[s], 8'h3C);
      chk("direction kept", p_oe[s], exp_v);
      host.rd(pc, rv);
      chk("data read", rv, s ? ((8'h3C & exp_v) | (PINS & ~exp_v)) : PINS);
      // flag bits ignore host writes
      host.wr(cc, 8'hFF);
      host.rd(cc, rv);
      chk("ctrl write", rv, 8'h3F);
      chk("aux drive", {6'h0, aux_oe[s], aux_out[s]}, 8'h03);
      // edges on a driven aux line must not set its flag
      @(negedge sys_clk) lines[s * 2 + 1] = 1'b1;
      cyc(4);
      @(negedge sys_clk) lines[s * 2 + 1] = 1'b0;
      cyc(4);
      host.rd(cc, rv);
      chk("aux output no flag", rv, 8'h3F);
      host.wr(cc, 8'h30);
      chk("aux low", {6'h0, aux_oe[s], aux_out[s]}, 8'h02);
    end
    // every section, line and edge choice once; each line with enable on and off
    for (int i = 0; i < 8; i++) begin
      flag_case(i / 4, (i / 2) % 2, i[0], i[0] ^ i[1]);
    end
    give_verdict();
  end
endmodule

/* test/pcrb_host_model.sv */
// behavioural host cpu that drives the adapter's parallel bus
module pcrb_host_model
  import pcrb_pkg::*;
(
  input wire logic sys_clk,
  output logic bus_e,
  output pcrb_bus_req_s bus_req,
  input wire logic [7:0] bus_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // idle bus at time zero
  initial begin
    bus_e = 1'b0;
    bus_req = '0;
  end
  // ==========================================================
  // one bus cycle, launched after a falling edge, taken at the next rising edge
  task automatic access(input logic rw, input logic [1:0] code, input logic [7:0] d);
    @(negedge sys_clk);
    bus_e <= 1'b1;
    bus_req <= '{cs: 1'b1, rw: rw, reg_select_hi: code[1], reg_select_lo: code[0],
                 wdata: d};
    @(negedge sys_clk);
    bus_e <= 1'b0;
    // released lines invert, so a decode of stale values cannot pass
    bus_req <= '{cs: 1'b0, rw: ~rw, reg_select_hi: ~code[1], reg_select_lo: ~code[0],
                 wdata: ~d};
  endtask
  task automatic wr(input logic [1:0] code, input logic [7:0] d);
    access(1'b0, code, d);
  endtask
  // read data is registered at the taking edge and stands until the next read
  task automatic rd(input logic [1:0] code, output logic [7:0] d);
    access(1'b1, code, 8'h00);
    d = bus_rdata;
  endtask
endmodule
